// ### hw/nand_page_ecc.sv
// nand page ecc engine: parity accumulation, checking and register port
module nand_page_ecc
   import ecc_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire nand_bus_t nand_bus,
   input wire reg_req_t reg_req,
   output logic [31:0] reg_rdata
);

   // ***********************************
   // state
   // ***********************************
   typedef struct packed {
      phase_t ph;
      logic rd_op;
      logic [1:0] page;
      logic [1:0] gran;
      logic wide;
      logic [11:0] idx;
      logic [3:0] span;
      logic [15:0] colx;
      logic [11:0] rp;
      logic [11:0] rn;
      logic [1:0] part;
      logic [31:0] stored;
      logic [15:0][3:0] flags;
   } state_t;

   state_t q;
   state_t d;

   logic clr_cmd;
   logic clr_sw;
   logic clr_any;
   logic take_word;
   logic span_end;
   logic last_span;
   logic last_part;
   logic [15:0] w;
   logic wpar;
   logic [15:0] colx_n;
   logic [11:0] rp_n;
   logic [11:0] rn_n;
   logic [11:0] rmask;
   logic [3:0] rowb;
   logic [2:0] cb;
   logic [4:0] nspan;
   logic split;
   logic [31:0] code_n;
   logic [31:0] stored_n;
   logic [31:0] comp;
   logic [31:0] syn;
   logic [15:0] pm;
   logic [15:0] nm;
   logic [15:0] umask;
   logic ev_fire;
   logic ev_none;
   logic ev_single;
   logic ev_code;
   logic [11:0] bad_ofs;
   logic [3:0] bad_bit;
   logic st_we;
   logic [3:0] st_widx;
   logic [31:0] st_wdata;
   logic a_re;
   logic [4:0] slot;
   logic [31:0] b_alt;

   // ***********************************
   // code construction
   // ***********************************
   // parity half sits in the low bits, inverse parity half above it
   function automatic logic [31:0] make_code(input logic [15:0] cx, input logic [11:0] pr,
         input logic [11:0] nr, input logic [11:0] rm, input logic [2:0] cbits,
         input logic sp);
      logic [3:0] cp;
      logic [3:0] cn;
      logic [15:0] pv;
      logic [15:0] nv;
      cp = {^(cx & COL_P8), ^(cx & COL_P4), ^(cx & COL_P2), ^(cx & COL_P1)};
      cn = {^(cx & COL_N8), ^(cx & COL_N4), ^(cx & COL_N2), ^(cx & COL_N1)};
      if (cbits == COLB_BYTE) begin
         cp[3] = 1'b0;
         cn[3] = 1'b0;
      end
      pv = (16'(pr & rm) << cbits) | {12'h000, cp};
      nv = (16'(nr & rm) << cbits) | {12'h000, cn};
      if (sp) return {8'h00, nv[11:0], pv[11:0]};
      return {nv, pv};
   endfunction

   // register slot of a parity result address: {hit, index}
   function automatic logic [4:0] pr_slot(input logic [7:0] a);
      if (a == OFS_PR0) return 5'h10;
      if (a == OFS_PR1) return {1'b1, SLOT_PR1};
      if (a >= OFS_PR2 && a <= OFS_PR15 && a[WORD_SHIFT-1:0] == 2'b00) begin
         return {1'b1, 4'((a - OFS_PR2) >> WORD_SHIFT) + SLOT_PR2};
      end
      return 5'h00;
   endfunction

   // ***********************************
   // geometry
   // ***********************************
   assign rowb = row_bits(q.page, q.gran, q.wide);
   assign split = split_code(q.gran, q.wide);
   assign cb = q.wide ? COLB_WIDE : COLB_BYTE;
   assign nspan = 5'(5'h1 << (page_log2(q.page) - rowb));
   assign rmask = 12'((13'h1 << rowb) - 13'h1);
   assign umask = 16'((17'h1 << (5'(rowb) + 5'(cb))) - 17'h1);

   // ***********************************
   // accumulation
   // ***********************************
   assign w = q.wide ? nand_bus.d : {8'h00, nand_bus.d[7:0]};
   assign wpar = ^w;
   assign colx_n = q.colx ^ w;
   assign rp_n = q.rp ^ ({12{wpar}} & q.idx);
   assign rn_n = q.rn ^ ({12{wpar}} & ~q.idx);
   assign code_n = make_code(colx_n, rp_n, rn_n, rmask, cb, split);
   assign take_word = nand_bus.data && (q.ph == PH_ADDR || q.ph == PH_MAIN);
   assign span_end = q.idx == rmask;
   assign last_span = {1'b0, q.span} == nspan - 5'h1;

   // ***********************************
   // checking
   // ***********************************
   assign last_part = q.wide ? q.part == 2'h1 : q.part == 2'h3;
   assign stored_n = q.wide ? {nand_bus.d, q.stored[31:16]}
                            : {nand_bus.d[7:0], q.stored[31:8]};
   assign ev_fire = nand_bus.data && q.ph == PH_SPARE && last_part;
   assign syn = comp ^ stored_n;
   assign pm = (split ? {4'h0, syn[11:0]} : syn[15:0]) & umask;
   assign nm = (split ? {4'h0, syn[23:12]} : syn[31:16]) & umask;
   assign ev_none = pm == 16'h0000 && nm == 16'h0000;
   assign ev_single = (pm ^ nm) == umask;
   assign ev_code = $countones({pm, nm}) == 1;
   assign bad_ofs = 12'({8'h00, q.span} << rowb) | 12'(pm >> cb);
   assign bad_bit = pm[3:0] & (q.wide ? COLM_WIDE : COLM_BYTE);

   // ***********************************
   // start and clear conditions
   // ***********************************
   assign clr_cmd = nand_bus.cmd &&
                    (nand_bus.d[7:0] == CMD_READ || nand_bus.d[7:0] == CMD_PROG);
   assign clr_sw = reg_req.wr && reg_req.addr == OFS_CTRL && reg_req.wdata[CTRL_CLR];
   assign clr_any = clr_cmd || clr_sw;

   // ***********************************
   // next state
   // ***********************************
   always_comb begin
      d = q;
      st_we = 1'b0;
      st_widx = q.span;
      st_wdata = WORD_ZERO;
      a_re = 1'b0;
      if (reg_req.wr && reg_req.addr == OFS_MODE) begin
         d.page = reg_req.wdata[MODE_PAGE +: 2];
         d.gran = reg_req.wdata[MODE_GRAN +: 2];
         d.wide = reg_req.wdata[MODE_WIDE];
      end
      unique case (q.ph)
         PH_IDLE, PH_DONE: begin
            // results stay locked here until the next read or program command or soft clear
            d.ph = q.ph;
         end
         PH_CMD: begin
            if (nand_bus.addr) begin
               d.ph = PH_ADDR;
            end
         end
         PH_ADDR, PH_MAIN: begin
            if (take_word) begin
               d.ph = PH_MAIN;
               d.colx = colx_n;
               d.rp = rp_n;
               d.rn = rn_n;
               d.idx = q.idx + 12'h001;
               if (span_end) begin
                  // code of the finished span goes to its result slot
                  st_we = 1'b1;
                  st_wdata = code_n;
                  d.colx = 16'h0000;
                  d.rp = 12'h000;
                  d.rn = 12'h000;
                  d.idx = 12'h000;
                  d.span = q.span + 4'h1;
                  if (last_span) begin
                     d.span = 4'h0;
                     d.ph = q.rd_op ? PH_SPARE : PH_DONE;
                  end
               end
            end
         end
         PH_SPARE: begin
            if (nand_bus.data) begin
               d.stored = stored_n;
               d.part = q.part + 2'h1;
               // fetch this span's computed code ahead of the last part
               a_re = q.part == 2'h0;
               if (last_part) begin
                  d.part = 2'h0;
                  st_we = 1'b1;
                  d.span = q.span + 4'h1;
                  if (last_span) begin
                     d.ph = PH_DONE;
                  end
                  if (ev_none) begin
                     d.flags[q.span] = 4'h0;
                  end else if (ev_single) begin
                     d.flags[q.span][FLAG_REC] = 1'b1;
                     st_wdata = {16'h0000, bad_ofs, bad_bit};
                  end else if (ev_code) begin
                     d.flags[q.span][FLAG_CODE] = 1'b1;
                  end else begin
                     d.flags[q.span][FLAG_REC] = 1'b1;
                     d.flags[q.span][FLAG_MUL] = 1'b1;
                  end
               end
            end
         end
         default: begin
            d.ph = PH_IDLE;
         end
      endcase
      if (clr_cmd) begin
         // counting restarts at word zero of the page
         d.ph = PH_CMD;
         d.rd_op = nand_bus.d[7:0] == CMD_READ;
         d.idx = 12'h000;
         d.span = 4'h0;
         d.colx = 16'h0000;
         d.rp = 12'h000;
         d.rn = 12'h000;
         d.part = 2'h0;
         d.flags = '0;
      end
      if (clr_sw) begin
         d.flags = '0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ***********************************
   // register read path
   // ***********************************
   assign slot = pr_slot(reg_req.addr);

   always_comb begin
      b_alt = WORD_ZERO;
      if (reg_req.addr == OFS_MODE) begin
         b_alt[MODE_PAGE +: 2] = q.page;
         b_alt[MODE_GRAN +: 2] = q.gran;
         b_alt[MODE_WIDE] = q.wide;
      end else if (reg_req.addr == OFS_SR1) begin
         b_alt = q.flags[7:0];
      end else if (reg_req.addr == OFS_SR2) begin
         b_alt = q.flags[15:8];
      end
   end

   parity_store u_store (
      .mclk(mclk),
      .nrst(nrst),
      .clr(clr_any),
      .we(st_we),
      .widx(st_widx),
      .wdata(st_wdata),
      .a_re(a_re),
      .a_idx(q.span),
      .a_q(comp),
      .b_re(reg_req.rd),
      .b_mem(slot[4]),
      .b_idx(slot[3:0]),
      .b_alt(b_alt),
      .b_q(reg_rdata)
   );

   // ***********************************
   // assertions
   // ***********************************
   default clocking ck @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   read_start_a: assert property (nand_bus.cmd && nand_bus.d[7:0] == CMD_READ
         |=> q.rd_op && q.ph == PH_CMD)
      else $error("read command did not start a read");

   cmd_clear_a: assert property (clr_cmd |=> q.flags == '0)
      else $error("command did not clear status");

   soft_clear_a: assert property (clr_sw |=> q.flags == '0)
      else $error("soft clear did not clear status");

   zero_noop_a: assert property (reg_req.wr && reg_req.addr == OFS_CTRL &&
         !reg_req.wdata[CTRL_CLR] && !clr_cmd && !ev_fire |=> $stable(q.flags))
      else $error("writing zero changed status");

   hold_done_a: assert property (q.ph == PH_DONE && !clr_any
         |=> q.ph == PH_DONE && $stable(q.flags))
      else $error("locked results changed");

   write_done_a: assert property (take_word && span_end && last_span && !q.rd_op &&
         !clr_any |=> q.ph == PH_DONE)
      else $error("write page did not end");

   no_error_a: assert property (ev_fire && ev_none && !clr_any
         |=> q.flags[$past(q.span)] == 4'h0)
      else $error("flag set without error");

   single_fix_a: assert property (ev_fire && ev_single && !clr_any
         |=> q.flags[$past(q.span)] == 4'h1)
      else $error("single error not flagged alone");

   code_fault_a: assert property (ev_fire && !ev_none && !ev_single && ev_code &&
         !clr_any |=> q.flags[$past(q.span)][FLAG_CODE])
      else $error("code fault not flagged");

   multi_fault_a: assert property (ev_fire && !ev_none && !ev_single && !ev_code &&
         !clr_any |=> q.flags[$past(q.span)][FLAG_MUL])
      else $error("multiple fault not flagged");

   status_read_a: assert property (reg_req.rd && reg_req.addr == OFS_SR1
         |=> reg_rdata == $past(q.flags[7:0]))
      else $error("status read wrong");

   single_cover_c: cover property (ev_fire && ev_single);
   clean_cover_c: cover property (ev_fire && ev_none);
   write_cover_c: cover property (take_word && span_end && last_span && !q.rd_op);

endmodule

// ### hw/ecc_pkg.sv
// shared constants, types and helpers of the nand page ecc engine
//
// Notes on behaviour
// - fix one bad bit, flag two
// - beyond two bad bits no correction
// - page words are 8 or 16 bits
// - start on read 00h or program 80h
// - results held until next start condition or soft clear
// - zero syndrome leaves every flag clear
// - single data error: correctable flag, location
// - single bad code bit: code fault flag
// - unrecoverable errors set multi fault flag
// - read or program command or soft clear wipes results
// - hamming style row/column sec-ded parity code
// - 24-bit code per 256/512 byte span
// - 32-bit code for whole page
// - registers through the peripheral register port
// - row parity pairs from word index bits
// - geometry 00..11 is 528..4224 words
// - granularity 00 page, 01 256, 10 512 (8-bit words only, 16-bit words always use the whole page)
// - clear bit one wipes results, zero nothing
package ecc_pkg;

   // ***********************************
   // register map and fields
   // ***********************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_MODE = 8'h04;
   localparam logic [7:0] OFS_SR1 = 8'h08;
   localparam logic [7:0] OFS_PR0 = 8'h0C;
   localparam logic [7:0] OFS_PR1 = 8'h10;
   localparam logic [7:0] OFS_SR2 = 8'h14;
   localparam logic [7:0] OFS_PR2 = 8'h18;
   localparam logic [7:0] OFS_PR15 = 8'h4C;
   localparam int CTRL_CLR = 0;
   localparam int MODE_PAGE = 0;
   localparam int MODE_GRAN = 4;
   localparam int MODE_WIDE = 8;
   localparam int FLAG_REC = 0;
   localparam int FLAG_CODE = 1;
   localparam int FLAG_MUL = 2;
   localparam logic [3:0] SLOT_PR1 = 4'h1;
   localparam logic [3:0] SLOT_PR2 = 4'h2;
   localparam int WORD_SHIFT = 2;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ***********************************
   // flash commands and geometry
   // ***********************************
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_PROG = 8'h80;
   localparam logic [1:0] GRAN_PAGE = 2'h0;
   localparam logic [1:0] GRAN_256 = 2'h1;
   localparam logic [1:0] GRAN_512 = 2'h2;
   localparam logic [3:0] LOG2_528 = 4'h9;
   localparam logic [3:0] LOG2_1056 = 4'hA;
   localparam logic [3:0] LOG2_2112 = 4'hB;
   localparam logic [3:0] LOG2_4224 = 4'hC;
   localparam logic [3:0] LOG2_S256 = 4'h8;
   localparam logic [3:0] LOG2_S512 = 4'h9;
   localparam logic [2:0] COLB_BYTE = 3'h3;
   localparam logic [2:0] COLB_WIDE = 3'h4;
   localparam logic [3:0] COLM_BYTE = 4'h7;
   localparam logic [3:0] COLM_WIDE = 4'hF;

   // ***********************************
   // column parity bit groups
   // ***********************************
   localparam logic [15:0] COL_P1 = 16'hAAAA;
   localparam logic [15:0] COL_N1 = 16'h5555;
   localparam logic [15:0] COL_P2 = 16'hCCCC;
   localparam logic [15:0] COL_N2 = 16'h3333;
   localparam logic [15:0] COL_P4 = 16'hF0F0;
   localparam logic [15:0] COL_N4 = 16'h0F0F;
   localparam logic [15:0] COL_P8 = 16'hFF00;
   localparam logic [15:0] COL_N8 = 16'h00FF;

   // ***********************************
   // types
   // ***********************************
   typedef enum logic [2:0] {
      PH_IDLE = 3'b000,
      PH_CMD = 3'b001,
      PH_ADDR = 3'b010,
      PH_MAIN = 3'b011,
      PH_SPARE = 3'b100,
      PH_DONE = 3'b101
   } phase_t;

   typedef struct packed {
      logic cmd;
      logic addr;
      logic data;
      logic [15:0] d;
   } nand_bus_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

   // ***********************************
   // geometry helpers
   // ***********************************
   function automatic logic [3:0] page_log2(input logic [1:0] page);
      unique case (page)
         2'h0: return LOG2_528;
         2'h1: return LOG2_1056;
         2'h2: return LOG2_2112;
         2'h3: return LOG2_4224;
      endcase
   endfunction

   function automatic logic [3:0] row_bits(input logic [1:0] page, input logic [1:0] gran,
         input logic wide);
      if (!wide && gran == GRAN_256) return LOG2_S256;
      if (!wide && gran == GRAN_512) return LOG2_S512;
      return page_log2(page);
   endfunction

   function automatic logic split_code(input logic [1:0] gran, input logic wide);
      return !wide && (gran == GRAN_256 || gran == GRAN_512);
   endfunction

endpackage

// ### hw/parity_store.sv
// parity result store: sixteen words with two registered read ports
module parity_store
   import ecc_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clr,
   input wire logic we,
   input wire logic [3:0] widx,
   input wire logic [31:0] wdata,
   input wire logic a_re,
   input wire logic [3:0] a_idx,
   output logic [31:0] a_q,
   input wire logic b_re,
   input wire logic b_mem,
   input wire logic [3:0] b_idx,
   input wire logic [31:0] b_alt,
   output logic [31:0] b_q
);

   typedef struct packed {
      logic [15:0][31:0] words;
      logic [31:0] a_q;
      logic [31:0] b_q;
   } store_t;

   store_t q;
   store_t d;

   // clear beats a same-cycle write; port b returns zero when idle
   always_comb begin
      d = q;
      if (we) begin
         d.words[widx] = wdata;
      end
      if (clr) begin
         d.words = '0;
      end
      if (a_re) begin
         d.a_q = q.words[a_idx];
      end
      d.b_q = WORD_ZERO;
      if (b_re) begin
         d.b_q = b_mem ? q.words[b_idx] : b_alt;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign a_q = q.a_q;
   assign b_q = q.b_q;

endmodule

// ### testbench/nand_flash_model.sv
// behavioural nand flash page that plays its bus cycles onto the watched flash bus
module nand_flash_model
   import ecc_pkg::*;
(
   input wire logic mclk,
   output nand_bus_t nand_bus
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0] mem [0:4095];

   initial begin
      nand_bus = '0;
   end

   // one command, one address cycle, then n back-to-back words from word 0
   task automatic xfer(input logic [7:0] op, input int n);
      @(posedge mclk);
      nand_bus <= '{cmd: 1'b1, addr: 1'b0, data: 1'b0, d: {8'h00, op}};
      @(posedge mclk);
      nand_bus <= '{cmd: 1'b0, addr: 1'b1, data: 1'b0, d: 16'h0000};
      for (int j = 0; j < n; j++) begin
         @(posedge mclk);
         nand_bus <= '{cmd: 1'b0, addr: 1'b0, data: 1'b1, d: mem[j]};
      end
      @(posedge mclk);
      // released bus never repeats the last word
      nand_bus <= '{cmd: 1'b0, addr: 1'b0, data: 1'b0, d: ~mem[n - 1]};
   endtask
endmodule

// ### testbench/nand_page_ecc_tb.sv
// self-checking bench for the nand page ecc engine
module nand_page_ecc_tb
   import ecc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic mclk;
   logic nrst;
   nand_bus_t nand_bus;
   reg_req_t reg_req;
   logic [31:0] reg_rdata;
   int err_total;
   int checks;
   logic [31:0] rd_q;
   logic [31:0] code_q;

   nand_page_ecc nand_page_ecc_inst (.mclk(mclk), .nrst(nrst), .nand_bus(nand_bus),
      .reg_req(reg_req), .reg_rdata(reg_rdata));
   nand_flash_model nand_flash_model_inst (.mclk(mclk), .nand_bus(nand_bus));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ***********************************
   // helpers
   // ***********************************
   task automatic end_of_test;
      if (err_total == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge mclk);
      reg_req <= '0;
   endtask

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: WORD_ZERO};
      @(posedge mclk);
      reg_req <= '0;
      #1;
      rd_q = reg_rdata;
      chk(name, exp, rd_q);
   endtask

   task automatic fill(input logic wide);
      for (int j = 0; j < 4096; j++) begin
         nand_flash_model_inst.mem[j] = wide ? 16'(j * 40503 + 7) : {8'h00, 8'(j * 37 + 11)};
      end
   endtask

   function automatic logic [31:0] ref_code(input int start, input int n, input int rb,
         input logic wide, input logic split);
      logic [15:0] w;
      logic x;
      logic [11:0] rp;
      logic [11:0] rn;
      logic [3:0] cp;
      logic [3:0] cn;
      logic [15:0] par;
      logic [15:0] inv;
      rp = '0;
      rn = '0;
      cp = '0;
      cn = '0;
      for (int j = 0; j < n; j++) begin
         w = nand_flash_model_inst.mem[start + j];
         x = ^w;
         for (int i = 0; i < rb; i++) begin
            if (j[i]) rp[i] ^= x;
            else rn[i] ^= x;
         end
         cp ^= {^(w & COL_P8), ^(w & COL_P4), ^(w & COL_P2), ^(w & COL_P1)};
         cn ^= {^(w & COL_N8), ^(w & COL_N4), ^(w & COL_N2), ^(w & COL_N1)};
      end
      if (!wide) begin
         cp[3] = 1'b0;
         cn[3] = 1'b0;
      end
      par = ({4'h0, rp} << (wide ? 4 : 3)) | {12'h000, cp};
      inv = ({4'h0, rn} << (wide ? 4 : 3)) | {12'h000, cn};
      return split ? {8'h00, inv[11:0], par[11:0]} : {inv, par};
   endfunction

   task automatic read_sr(input string name, input logic [31:0] exp);
      nand_flash_model_inst.xfer(CMD_READ, 516);
      rd_chk(name, OFS_SR1, exp);
   endtask

   // ***********************************
   // scenarios
   // ***********************************
   task automatic t_regs;
      rd_chk("mode reset", OFS_MODE, WORD_ZERO);
      rd_chk("sr1 reset", OFS_SR1, WORD_ZERO);
      rd_chk("pr15 reset", OFS_PR15, WORD_ZERO);
      rd_chk("unmapped", 8'h80, WORD_ZERO);
      reg_wr(OFS_MODE, 32'h0000_0113);
      rd_chk("mode rw", OFS_MODE, 32'h0000_0113);
      reg_wr(OFS_SR2, 32'hFFFF_FFFF);
      rd_chk("sr2 ro", OFS_SR2, WORD_ZERO);
      reg_wr(OFS_MODE, WORD_ZERO);
   endtask

   task automatic t_program;
      fill(1'b0);
      nand_flash_model_inst.xfer(CMD_PROG, 512);
      code_q = ref_code(0, 512, 9, 1'b0, 1'b0);
      rd_chk("pr0 program", OFS_PR0, code_q);
      nand_flash_model_inst.xfer(8'h70, 4);
      rd_chk("pr0 held", OFS_PR0, code_q);
      for (int k = 0; k < 4; k++) begin
         nand_flash_model_inst.mem[512 + k] = {8'h00, code_q[8 * k +: 8]};
      end
   endtask

   task automatic t_reads;
      read_sr("sr1 clean", WORD_ZERO);
      nand_flash_model_inst.mem[37] ^= 16'h0020;
      read_sr("sr1 single", 32'h0000_0001);
      rd_chk("pr0 location", OFS_PR0, 32'h0000_0255);
      nand_flash_model_inst.mem[37] ^= 16'h0020;
      nand_flash_model_inst.mem[513] ^= 16'h0004;
      read_sr("sr1 code", 32'h0000_0002);
      rd_chk("pr0 code", OFS_PR0, WORD_ZERO);
      nand_flash_model_inst.mem[513] ^= 16'h0004;
      nand_flash_model_inst.mem[10] ^= 16'h0001;
      nand_flash_model_inst.mem[300] ^= 16'h0040;
      read_sr("sr1 double", 32'h0000_0005);
      nand_flash_model_inst.mem[10] ^= 16'h0001;
      nand_flash_model_inst.mem[300] ^= 16'h0040;
   endtask

   task automatic t_clear;
      nand_flash_model_inst.mem[5] ^= 16'h0001;
      read_sr("sr1 word5", 32'h0000_0001);
      reg_wr(OFS_CTRL, WORD_ZERO);
      rd_chk("sr1 kept", OFS_SR1, 32'h0000_0001);
      rd_chk("pr0 kept", OFS_PR0, 32'h0000_0050);
      reg_wr(OFS_CTRL, 32'h0000_0001);
      rd_chk("sr1 cleared", OFS_SR1, WORD_ZERO);
      rd_chk("pr0 cleared", OFS_PR0, WORD_ZERO);
      read_sr("sr1 again", 32'h0000_0001);
      nand_flash_model_inst.xfer(CMD_PROG, 512);
      rd_chk("sr1 new cmd", OFS_SR1, WORD_ZERO);
      nand_flash_model_inst.mem[5] ^= 16'h0001;
   endtask

   task automatic t_gran;
      reg_wr(OFS_MODE, 32'h0000_0010);
      nand_flash_model_inst.xfer(CMD_PROG, 512);
      rd_chk("pr0 span256", OFS_PR0, ref_code(0, 256, 8, 1'b0, 1'b1));
      rd_chk("pr1 span256", OFS_PR1, ref_code(256, 256, 8, 1'b0, 1'b1));
      reg_wr(OFS_MODE, 32'h0000_0020);
      nand_flash_model_inst.xfer(CMD_PROG, 512);
      rd_chk("pr0 span512", OFS_PR0, ref_code(0, 512, 9, 1'b0, 1'b1));
   endtask

   // larger geometries, later result slots and the spare granularity code
   task automatic t_geom;
      reg_wr(OFS_MODE, 32'h0000_0001);
      nand_flash_model_inst.xfer(CMD_PROG, 1024);
      rd_chk("pr0 page1k", OFS_PR0, ref_code(0, 1024, 10, 1'b0, 1'b0));
      reg_wr(OFS_MODE, 32'h0000_0012);
      nand_flash_model_inst.xfer(CMD_PROG, 2048);
      rd_chk("pr2 span256", OFS_PR2, ref_code(512, 256, 8, 1'b0, 1'b1));
      rd_chk("pr7 span256", 8'h2C, ref_code(1792, 256, 8, 1'b0, 1'b1));
      reg_wr(OFS_MODE, 32'h0000_0033);
      nand_flash_model_inst.xfer(CMD_PROG, 4096);
      rd_chk("pr0 page4k", OFS_PR0, ref_code(0, 4096, 12, 1'b0, 1'b0));
   endtask

   task automatic t_wide;
      reg_wr(OFS_MODE, 32'h0000_0100);
      fill(1'b1);
      nand_flash_model_inst.xfer(CMD_PROG, 512);
      code_q = ref_code(0, 512, 9, 1'b1, 1'b0);
      rd_chk("pr0 wide", OFS_PR0, code_q);
      // stored code as two halfwords, low half first
      nand_flash_model_inst.mem[512] = code_q[15:0];
      nand_flash_model_inst.mem[513] = code_q[31:16];
      nand_flash_model_inst.mem[100] ^= 16'h1000;
      nand_flash_model_inst.xfer(CMD_READ, 514);
      rd_chk("sr1 wide", OFS_SR1, 32'h0000_0001);
      rd_chk("pr0 wide location", OFS_PR0, 32'h0000_064C);
   endtask

   // ***********************************
   // main sequence and watchdog
   // ***********************************
   initial begin
      nrst = 1'b0;
      reg_req = '0;
      err_total = 0;
      checks = 0;
      repeat (12) @(posedge mclk);
      nrst <= 1'b1;
      @(posedge mclk);
      t_regs;
      t_program;
      t_reads;
      t_clear;
      t_gran;
      t_geom;
      t_wide;
      end_of_test;
   end

   initial begin
      repeat (30000) @(posedge mclk);
      err_total++;
      end_of_test;
   end
endmodule
